/* File: hw/sfta_pkg.sv */
// sfta_pkg: constants and carrier types of the forwarding table access block.
// assumes one switch clock; register offsets are byte addresses on a 12-bit bus.
package sfta_pkg;

	// ----------------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------------
	localparam logic [11:0] VL_E0_OFS = 12'h400;
	localparam logic [11:0] VL_E1_OFS = 12'h404;
	localparam logic [11:0] VL_E2_OFS = 12'h408;
	localparam logic [11:0] VL_IDX_OFS = 12'h40C;
	localparam logic [11:0] VL_CTL_OFS = 12'h410;
	localparam logic [11:0] TBL_CTL_OFS = 12'h41C;
	localparam logic [11:0] ST_E1_OFS = 12'h420;
	localparam logic [11:0] ST_E2_OFS = 12'h424;
	localparam logic [11:0] ST_E3_OFS = 12'h428;
	localparam logic [11:0] ST_E4_OFS = 12'h42C;

	// ----------------------------------------------------------------------
	// writable bits and field positions
	// ----------------------------------------------------------------------
	localparam logic [31:0] ST_E1_MASK = 32'hFC000007;
	localparam logic [31:0] ST_E2_MASK = 32'hC000007F;
	localparam logic [31:0] ST_E3_MASK = 32'h007FFFFF;
	localparam logic [31:0] VL_E0_MASK = 32'h8F00707F;
	localparam logic [31:0] PORT_MASK7 = 32'h0000007F;
	localparam int ST_VALID_BIT = 31;
	localparam int ST_DROP_BIT = 29;
	localparam int ST_PRIO_LSB = 26;
	localparam int ST_BYPASS_BIT = 31;
	localparam int ST_GRPID_BIT = 30;
	localparam int ST_FID_LSB = 16;
	localparam int CTL_LAUNCH_BIT = 31;
	localparam int CTL_SEL_BIT = 27;
	localparam int CTL_ACT_BIT = 26;
	localparam int CTL_IDX_LSB = 16;
	localparam int VL_START_BIT = 7;
	localparam int VL_ACT_BIT = 0;
	localparam int VL_VALID_BIT = 31;
	localparam int VL_FOPT_BIT = 27;
	localparam int VL_PRIO_LSB = 24;
	localparam int VL_MSTP_LSB = 12;
	localparam int DA_GROUP_BIT = 40;

	// ----------------------------------------------------------------------
	// table sizes
	// ----------------------------------------------------------------------
	localparam int ST_ENTRIES = 16;
	localparam int RM_ENTRIES = 48;
	localparam int RM_GROUPS = 8;
	localparam int RM_PER_GROUP = 6;
	localparam int VL_ENTRIES = 4096;

	typedef enum logic {SFTA_IDLE, SFTA_RUN} sfta_op_type;

	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} sfta_bus_req_type;

	typedef struct packed {
		logic req;
		logic [11:0] vid;
		logic [47:0] da;
	} sfta_lookup_req_type;

	typedef struct packed {
		logic valid;
		logic fwd_opt;
		logic [2:0] prio;
		logic [2:0] mstp;
		logic [6:0] filter_group_identifier;
		logic [6:0] untag;
		logic [6:0] member;
	} sfta_vlan_entry_type;

	typedef struct packed {
		logic valid;
		logic vlan_hit;
		sfta_vlan_entry_type vlan;
		logic [11:0] alu_index;
		logic st_hit;
		logic st_drop;
		logic [2:0] st_prio;
		logic [6:0] st_fwd;
		logic [6:0] rm_fwd;
	} sfta_result_type;

endpackage

/* File: hw/sfta_top.sv */
// sfta_top: register access and lookup use of the static, reserved multicast
// and vlan tables. assumes lookup requests and port state come from logic on clk.
//
// Function
// - port_state_bypass bit bypasses blocked port state
// - group-id bit makes multicast match compare filter id
// - seven-bit forward mask, bit 0 is port 1
// - third word: filter id 22:16, mac 47:32
// - fourth word holds mac bits 31:0
// - 48 reserved entries indexed by address low bits
// - eight shared groups, one write updates group
// - table choice 1 selects reserved multicast
// - operation bit: 0 write, 1 read
// - launch flag starts operation, self clears
// - read result in data word after flag clears
// - 4096 vlan entries, used only in vlan mode
// - vlan entry valid only when flag is 1
// - forward option selects membership mask forwarding
// - vlan entry holds priority and tree instance
// - filter id hashed with address for index
// - untag mask bit strips tag at port
// - membership mask, lsb is port 1
// - twelve-bit vlan index equals vid
// - start bit 7 self clears, results in words
// - table choice 0 selects 16-entry static table
`timescale 1ns/10ps
module sfta_top
	import sfta_pkg::*;
#(
	parameter int VL_DEPTH = VL_ENTRIES
) (
	// clock and reset
	input logic clk,
	input logic reset_n,
	// register port
	input sfta_bus_req_type bus,
	output logic [31:0] rd_data,
	// lookup side
	input logic vlan_mode_en,
	input logic [6:0] port_open,
	input sfta_lookup_req_type lk,
	output sfta_result_type result
);

	// ----------------------------------------------------------------------
	// state
	// ----------------------------------------------------------------------
	typedef struct packed {
		logic [31:0] w1;
		logic [31:0] w2;
		logic [31:0] w3;
		logic [31:0] w4;
		logic [5:0] ctl_idx;
		logic ctl_sel;
		logic ctl_act;
		sfta_op_type st_op;
		logic [31:0] v0;
		logic [31:0] v1;
		logic [31:0] v2;
		logic [11:0] vl_idx;
		logic vl_act;
		sfta_op_type vl_op;
		logic [31:0] rdata;
		sfta_result_type res;
		logic [ST_ENTRIES-1:0][127:0] st_tbl;
		logic [RM_GROUPS-1:0][6:0] rm_tbl;
		sfta_vlan_entry_type [VL_DEPTH-1:0] vl_tbl;
	} sfta_state_type;

	sfta_state_type s_q;
	sfta_state_type s_d;
	logic [1:0] rst_sync_q;
	logic rst_n;
	logic [31:0] rd;
	logic [2:0] grp;
	logic [127:0] st_ent;
	logic st_hit;
	sfta_vlan_entry_type lk_vl;
	logic vhit;
	logic [6:0] fid_eff;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// reserved multicast index to its shared group
	function automatic logic [2:0] rm_group(input logic [5:0] idx);
		logic [5:0] g;
		g = idx / 6'(RM_PER_GROUP);
		return g[2:0];
	endfunction

	// static entry match; group id compared only on multicast with bit set
	function automatic logic st_match(input logic [127:0] e, input logic [47:0] da,
			input logic [6:0] filter_group_identifier);
		logic [31:0] e1;
		logic [31:0] e2;
		logic [31:0] e3;
		logic [31:0] e4;
		logic fid_ok;
		{e1, e2, e3, e4} = e;
		fid_ok = !(da[DA_GROUP_BIT] && e2[ST_GRPID_BIT]) || (e3[ST_FID_LSB +: 7] == filter_group_identifier);
		return e1[ST_VALID_BIT] && ({e3[15:0], e4} == da) && fid_ok;
	endfunction

	// ----------------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		rd = 32'h0;
		grp = rm_group(s_q.ctl_idx);
		st_ent = 128'h0;
		st_hit = 1'b0;

		// shared data and control; all ignored while a static or reserved multicast operation runs
		if (bus.wr && s_q.st_op == SFTA_IDLE) begin
			if (bus.addr == ST_E1_OFS) begin
				s_d.w1 = bus.wdata & ST_E1_MASK;
			end else if (bus.addr == ST_E2_OFS) begin
				s_d.w2 = bus.wdata & ST_E2_MASK;
			end else if (bus.addr == ST_E3_OFS) begin
				s_d.w3 = bus.wdata & ST_E3_MASK;
			end else if (bus.addr == ST_E4_OFS) begin
				s_d.w4 = bus.wdata;
			end else if (bus.addr == TBL_CTL_OFS) begin
				s_d.ctl_idx = bus.wdata[CTL_IDX_LSB +: 6];
				s_d.ctl_sel = bus.wdata[CTL_SEL_BIT];
				s_d.ctl_act = bus.wdata[CTL_ACT_BIT];
				if (bus.wdata[CTL_LAUNCH_BIT]) begin
					s_d.st_op = SFTA_RUN;
				end
			end
		end

		// vlan data and control
		if (bus.wr && s_q.vl_op == SFTA_IDLE) begin
			if (bus.addr == VL_E0_OFS) begin
				s_d.v0 = bus.wdata & VL_E0_MASK;
			end else if (bus.addr == VL_E1_OFS) begin
				s_d.v1 = bus.wdata & PORT_MASK7;
			end else if (bus.addr == VL_E2_OFS) begin
				s_d.v2 = bus.wdata & PORT_MASK7;
			end else if (bus.addr == VL_IDX_OFS) begin
				s_d.vl_idx = bus.wdata[11:0];
			end else if (bus.addr == VL_CTL_OFS) begin
				s_d.vl_act = bus.wdata[VL_ACT_BIT];
				if (bus.wdata[VL_START_BIT]) begin
					s_d.vl_op = SFTA_RUN;
				end
			end
		end

		// static or reserved multicast operation, one cycle long
		case (s_q.st_op)
			SFTA_RUN: begin
				s_d.st_op = SFTA_IDLE;
				if (s_q.ctl_sel) begin
					if (s_q.ctl_idx < 6'(RM_ENTRIES)) begin
						if (!s_q.ctl_act) begin
							s_d.rm_tbl[grp] = s_q.w2[6:0];
						end else begin
							s_d.w2 = {25'h0, s_q.rm_tbl[grp]};
						end
					end else if (s_q.ctl_act) begin
						s_d.w2 = 32'h0;
					end
				end else if (!s_q.ctl_act) begin
					s_d.st_tbl[s_q.ctl_idx[3:0]] = {s_q.w1, s_q.w2, s_q.w3, s_q.w4};
				end else begin
					{s_d.w1, s_d.w2, s_d.w3, s_d.w4} = s_q.st_tbl[s_q.ctl_idx[3:0]];
				end
			end
			default: begin
			end
		endcase

		// vlan operation, one cycle long
		case (s_q.vl_op)
			SFTA_RUN: begin
				s_d.vl_op = SFTA_IDLE;
				if (!s_q.vl_act) begin
					s_d.vl_tbl[s_q.vl_idx] = '{valid: s_q.v0[VL_VALID_BIT],
						fwd_opt: s_q.v0[VL_FOPT_BIT], prio: s_q.v0[VL_PRIO_LSB +: 3],
						mstp: s_q.v0[VL_MSTP_LSB +: 3], filter_group_identifier: s_q.v0[6:0],
						untag: s_q.v1[6:0], member: s_q.v2[6:0]};
				end else begin
					s_d.v0 = 32'h0;
					s_d.v0[VL_VALID_BIT] = s_q.vl_tbl[s_q.vl_idx].valid;
					s_d.v0[VL_FOPT_BIT] = s_q.vl_tbl[s_q.vl_idx].fwd_opt;
					s_d.v0[VL_PRIO_LSB +: 3] = s_q.vl_tbl[s_q.vl_idx].prio;
					s_d.v0[VL_MSTP_LSB +: 3] = s_q.vl_tbl[s_q.vl_idx].mstp;
					s_d.v0[6:0] = s_q.vl_tbl[s_q.vl_idx].filter_group_identifier;
					s_d.v1 = {25'h0, s_q.vl_tbl[s_q.vl_idx].untag};
					s_d.v2 = {25'h0, s_q.vl_tbl[s_q.vl_idx].member};
				end
			end
			default: begin
			end
		endcase

		// read decode; launch flags show the running operation
		if (bus.addr == ST_E1_OFS) begin
			rd = s_q.w1;
		end else if (bus.addr == ST_E2_OFS) begin
			rd = s_q.w2;
		end else if (bus.addr == ST_E3_OFS) begin
			rd = s_q.w3;
		end else if (bus.addr == ST_E4_OFS) begin
			rd = s_q.w4;
		end else if (bus.addr == TBL_CTL_OFS) begin
			rd[CTL_LAUNCH_BIT] = (s_q.st_op == SFTA_RUN);
			rd[CTL_SEL_BIT] = s_q.ctl_sel;
			rd[CTL_ACT_BIT] = s_q.ctl_act;
			rd[CTL_IDX_LSB +: 6] = s_q.ctl_idx;
		end else if (bus.addr == VL_E0_OFS) begin
			rd = s_q.v0;
		end else if (bus.addr == VL_E1_OFS) begin
			rd = s_q.v1;
		end else if (bus.addr == VL_E2_OFS) begin
			rd = s_q.v2;
		end else if (bus.addr == VL_IDX_OFS) begin
			rd = {20'h0, s_q.vl_idx};
		end else if (bus.addr == VL_CTL_OFS) begin
			rd[VL_START_BIT] = (s_q.vl_op == SFTA_RUN);
			rd[VL_ACT_BIT] = s_q.vl_act;
		end
		s_d.rdata = bus.rd ? rd : 32'h0;

		// lookup: vlan entry only counts in vlan mode and when valid
		// vid above the table depth is not wrapped; callers keep it inside the table
		lk_vl = s_q.vl_tbl[lk.vid];
		vhit = vlan_mode_en && lk_vl.valid;
		fid_eff = vhit ? lk_vl.filter_group_identifier : 7'h0;
		// search from the top so the lowest matching index wins
		for (int i = ST_ENTRIES - 1; i >= 0; i--) begin
			if (st_match(s_q.st_tbl[i], lk.da, fid_eff)) begin
				st_hit = 1'b1;
				st_ent = s_q.st_tbl[i];
			end
		end
		s_d.res.valid = lk.req;
		if (lk.req) begin
			s_d.res.vlan_hit = vhit;
			s_d.res.vlan = vhit ? lk_vl : '0;
			s_d.res.alu_index = lk.da[11:0] ^ lk.da[23:12] ^ lk.da[35:24] ^ lk.da[47:36]
				^ {5'h0, fid_eff};
			s_d.res.st_hit = st_hit;
			s_d.res.st_drop = st_ent[96 + ST_DROP_BIT];
			s_d.res.st_prio = st_ent[96 + ST_PRIO_LSB +: 3];
			s_d.res.st_fwd = st_ent[70:64] & (st_ent[64 + ST_BYPASS_BIT] ? 7'h7F : port_open);
			s_d.res.rm_fwd = (lk.da[5:0] < 6'(RM_ENTRIES)) ? s_q.rm_tbl[rm_group(lk.da[5:0])]
				: 7'h0;
		end
	end

	// one register for all state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data = s_q.rdata;
	assign result = s_q.res;

	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// table operations
	a_launch_self_clear: assert property (
		bus.wr && bus.addr == TBL_CTL_OFS && bus.wdata[CTL_LAUNCH_BIT] && s_q.st_op == SFTA_IDLE
		|=> s_q.st_op == SFTA_RUN ##1 s_q.st_op == SFTA_IDLE)
		else $error("table launch flag did not run one cycle");
	a_vlan_start_clear: assert property (
		bus.wr && bus.addr == VL_CTL_OFS && bus.wdata[VL_START_BIT] && s_q.vl_op == SFTA_IDLE
		|=> s_q.vl_op == SFTA_RUN ##1 s_q.vl_op == SFTA_IDLE)
		else $error("vlan start bit did not run one cycle");
	a_busy_holds_data: assert property (
		s_q.st_op == SFTA_RUN && !s_q.ctl_act |=> s_q.w2 == $past(s_q.w2) && s_q.w4 == $past(s_q.w4))
		else $error("data words moved during a write operation");
	a_busy_launch_drop: assert property (
		bus.wr && bus.addr == TBL_CTL_OFS && s_q.st_op == SFTA_RUN
		|=> s_q.st_op == SFTA_IDLE && s_q.ctl_idx == $past(s_q.ctl_idx)
			&& s_q.ctl_act == $past(s_q.ctl_act))
		else $error("launch taken while an operation ran");
	a_rm_group_write: assert property (
		s_q.st_op == SFTA_RUN && s_q.ctl_sel && !s_q.ctl_act && s_q.ctl_idx < 6'(RM_ENTRIES)
		|=> s_q.rm_tbl[rm_group($past(s_q.ctl_idx))] == $past(s_q.w2[6:0]))
		else $error("reserved group not updated");
	a_rm_high_zero: assert property (
		s_q.st_op == SFTA_RUN && s_q.ctl_sel && s_q.ctl_act && s_q.ctl_idx >= 6'(RM_ENTRIES)
		|=> s_q.w2 == 32'h0 && s_q.rm_tbl == $past(s_q.rm_tbl))
		else $error("out of range reserved access misbehaved");
	a_rm_high_keep: assert property (
		s_q.st_op == SFTA_RUN && s_q.ctl_sel && !s_q.ctl_act && s_q.ctl_idx >= 6'(RM_ENTRIES)
		|=> s_q.rm_tbl == $past(s_q.rm_tbl))
		else $error("out of range reserved write changed a group");

	// lookup results come from the table state before the taking edge
	a_vlan_mode_gate: assert property (
		lk.req && !vlan_mode_en |=> s_q.res.valid && !s_q.res.vlan_hit)
		else $error("vlan hit outside vlan mode");
	a_vlan_valid_bit: assert property (
		s_q.vl_op == SFTA_RUN && !s_q.vl_act
		|=> s_q.vl_tbl[$past(s_q.vl_idx)].valid == $past(s_q.v0[VL_VALID_BIT]))
		else $error("vlan valid flag not stored");
	a_vlan_entry_out: assert property (
		lk.req && vlan_mode_en && s_q.vl_tbl[lk.vid].valid
		|=> result.vlan_hit && result.vlan == $past(s_q.vl_tbl[lk.vid]))
		else $error("vlan entry fields not passed to the result");
	a_mac_low_read: assert property (
		bus.rd && bus.addr == ST_E4_OFS |=> rd_data == $past(s_q.w4) ##1 rd_data == 32'h0 || $past(bus.rd))
		else $error("mac low word read wrong");
	a_miss_no_ports: assert property (
		result.valid && !result.st_hit |-> result.st_fwd == 7'h0)
		else $error("forward ports without static hit");
	a_rm_fwd_range: assert property (
		lk.req && lk.da[5:0] >= 6'(RM_ENTRIES) |=> result.rm_fwd == 7'h0)
		else $error("reserved ports for an address outside the table");

	// main scenarios
	c_rm_write: cover property (s_q.st_op == SFTA_RUN && s_q.ctl_sel && !s_q.ctl_act);
	c_st_read: cover property (s_q.st_op == SFTA_RUN && !s_q.ctl_sel && s_q.ctl_act);
	c_vlan_write: cover property (s_q.vl_op == SFTA_RUN && !s_q.vl_act);
	c_lookup_hit: cover property (result.valid && result.st_hit && result.vlan_hit);
	c_busy_launch: cover property (bus.wr && bus.addr == TBL_CTL_OFS && s_q.st_op == SFTA_RUN);

endmodule

/* File: sim/sfta_host_model.sv */
// sfta_host_model: host software side of the table access block.
// assumes callers run on clk; read data is taken in the cycle after the strobe.
`timescale 1ns/10ps
module sfta_host_model
	import sfta_pkg::*;
(
	// clock
	input logic clk,
	// register port
	output sfta_bus_req_type bus,
	input logic [31:0] rd_data
);
	// idle port from time zero
	initial begin
		bus = '0;
	end

	// ----------------------------------------------------------------------
	// bus cycles
	// ----------------------------------------------------------------------
	// one write cycle, strobe dropped at the edge that takes it
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask

	// one read cycle; data stand only in the following cycle
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 d = rd_data;
	endtask

	// control write then an immediate read, so the busy flag is seen
	// in the single cycle it stands; data words are loaded beforehand
	task automatic launch(input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 q = rd_data;
	endtask

	// two writes back to back; the second lands while an operation runs
	task automatic wr_pair(input logic [11:0] a, input logic [31:0] d0, input logic [31:0] d1);
		@(posedge clk);
		bus <= '{addr: a, wdata: d0, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '{addr: a, wdata: d1, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask
endmodule

/* File: sim/switch_forward_table_access_tb.sv */
// switch_forward_table_access_tb: register level test of the table access block.
// assumes the host model drives the register port and the bench drives lookups.
`timescale 1ns/10ps
module switch_forward_table_access_tb
	import sfta_pkg::*;
;
	logic clk;
	logic reset_n;
	logic vlan_mode_en;
	logic [6:0] port_open;
	sfta_lookup_req_type lk;
	sfta_bus_req_type bus;
	sfta_result_type result;
	logic [31:0] rd_data;
	logic [31:0] q;
	int bad_count;
	int n_checks;
	int i;
	logic [5:0] rm_idx [5] = '{6'h00, 6'h06, 6'h0B, 6'h0C, 6'h2F};
	logic [6:0] rm_exp [5] = '{7'h00, 7'h2A, 7'h2A, 7'h00, 7'h00};

	// ----------------------------------------------------------------------
	// design and host
	// ----------------------------------------------------------------------
	// small vlan depth keeps the run short
	sfta_top #(.VL_DEPTH(16)) DUT (.clk(clk), .reset_n(reset_n), .bus(bus), .rd_data(rd_data),
		.vlan_mode_en(vlan_mode_en), .port_open(port_open), .lk(lk), .result(result));
	sfta_host_model host (.clk(clk), .bus(bus), .rd_data(rd_data));

	// 25 MHz clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ----------------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// launch, see busy, then poll under a bound; a hang ends the run
	task automatic op(input logic [11:0] a, input logic [31:0] c, input int b);
		logic [31:0] s;
		int k;
		host.launch(a, c, s);
		check(32'(s[b]), 32'h1);
		for (k = 0; k < 8 && s[b] !== 1'b0; k++) begin
			host.rd(a, s);
		end
		check(32'(s[b]), 32'h0);
		if (s[b] !== 1'b0) begin
			summarize();
		end
	endtask

	// one lookup pulse; result is settled just after the taking edge
	task automatic look(input logic [11:0] v, input logic [47:0] da);
		@(posedge clk);
		lk <= '{req: 1'b1, vid: v, da: da};
		@(posedge clk);
		lk <= '0;
		#1;
		check(32'(result.valid), 32'h1);
	endtask

	// ----------------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------------
	initial begin
		reset_n = 1'b0;
		vlan_mode_en = 1'b0;
		port_open = 7'h0F;
		lk = '0;
		bad_count = 0;
		n_checks = 0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		// reset value and an unmapped place
		host.rd(ST_E4_OFS, q);
		check(q, 32'h0);
		host.rd(12'h500, q);
		check(q, 32'h0);
		// static entry 3, then wipe a word and read the entry back
		host.wr(ST_E1_OFS, 32'h94000002);
		host.wr(ST_E2_OFS, 32'h00000055);
		host.wr(ST_E3_OFS, 32'hFF801234);
		host.wr(ST_E4_OFS, 32'h89ABCDEF);
		op(TBL_CTL_OFS, 32'h80030000, CTL_LAUNCH_BIT);
		host.wr(ST_E4_OFS, 32'h0);
		op(TBL_CTL_OFS, 32'h84030000, CTL_LAUNCH_BIT);
		host.rd(ST_E1_OFS, q);
		check(q, 32'h94000002);
		host.rd(ST_E3_OFS, q);
		check(q, 32'h00001234);
		host.rd(ST_E4_OFS, q);
		check(q, 32'h89ABCDEF);
		look(12'h0, 48'h123489ABCDEF);
		check(32'(result.st_hit), 32'h1);
		check(32'(result.st_fwd), 32'h05);
		check(32'(result.st_prio), 32'h5);
		// bypass set: blocked ports no longer filter the mask
		host.wr(ST_E2_OFS, 32'hFFFFFF55);
		op(TBL_CTL_OFS, 32'h80030000, CTL_LAUNCH_BIT);
		look(12'h0, 48'h123489ABCDEF);
		check(32'(result.st_fwd), 32'h55);
		// a second launch while busy is dropped; the read of entry 3 stands
		host.wr_pair(TBL_CTL_OFS, 32'h84030000, 32'h80050000);
		host.rd(TBL_CTL_OFS, q);
		check(q, 32'h04030000);
		host.rd(ST_E2_OFS, q);
		check(q, 32'hC0000055);
		// reserved multicast: index 7 shares a group with 6..11
		host.wr(ST_E2_OFS, 32'h0000002A);
		op(TBL_CTL_OFS, 32'h88070000, CTL_LAUNCH_BIT);
		host.wr(ST_E2_OFS, 32'h0000007F);
		op(TBL_CTL_OFS, 32'h88320000, CTL_LAUNCH_BIT);
		for (i = 0; i < 5; i++) begin
			op(TBL_CTL_OFS, 32'h8C000000 | (32'(rm_idx[i]) << 16), CTL_LAUNCH_BIT);
			host.rd(ST_E2_OFS, q);
			check(q, 32'(rm_exp[i]));
		end
		op(TBL_CTL_OFS, 32'h8C320000, CTL_LAUNCH_BIT);
		host.rd(ST_E2_OFS, q);
		check(q, 32'h0);
		// vlan entry 9 written, first word wiped, read back
		host.wr(VL_E0_OFS, 32'h8B002011);
		host.wr(VL_E1_OFS, 32'h00000012);
		host.wr(VL_E2_OFS, 32'h0000006C);
		host.wr(VL_IDX_OFS, 32'h00000009);
		op(VL_CTL_OFS, 32'h00000080, VL_START_BIT);
		host.wr(VL_E0_OFS, 32'h0);
		op(VL_CTL_OFS, 32'h00000081, VL_START_BIT);
		host.rd(VL_E0_OFS, q);
		check(q, 32'h8B002011);
		host.rd(VL_E1_OFS, q);
		check(q, 32'h00000012);
		host.rd(VL_E2_OFS, q);
		check(q, 32'h0000006C);
		// lookups on the filled table: mode off, then mode on
		look(12'h9, 48'h0180C2000008);
		check(32'(result.vlan_hit), 32'h0);
		check(32'(result.rm_fwd), 32'h2A);
		@(posedge clk) vlan_mode_en <= 1'b1;
		look(12'h9, 48'h0180C2000008);
		check(32'(result.vlan_hit), 32'h1);
		check(32'(result.vlan), 32'({2'h3, 3'h3, 3'h2, 7'h11, 7'h12, 7'h6C}));
		check(32'(result.alu_index), 32'h0C3);
		// multicast static entry 5 matches only under its filter group
		host.wr(ST_E1_OFS, 32'hA0000000);
		host.wr(ST_E2_OFS, 32'h4000007F);
		host.wr(ST_E3_OFS, 32'h00110180);
		host.wr(ST_E4_OFS, 32'hC2000033);
		op(TBL_CTL_OFS, 32'h80050000, CTL_LAUNCH_BIT);
		look(12'h9, 48'h0180C2000033);
		check(32'(result.st_hit), 32'h1);
		check(32'(result.st_fwd), 32'h0F);
		check(32'(result.st_drop), 32'h1);
		check(32'(result.rm_fwd), 32'h00);
		look(12'h4, 48'h0180C2000033);
		check(32'(result.vlan_hit), 32'h0);
		check(32'(result.vlan), 32'h0);
		check(32'(result.st_hit), 32'h0);
		summarize();
	end
endmodule
